// [spwi_top.sv]
// Smart panel write interface: APB registers, word queue, beat sequencer.
// Assumes pin_share_select and the APB come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module spwi_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // DMA refill request
  output logic dma_req,
  // Pin sharing
  input wire logic pin_share_select,
  output logic panel_drive_en,
  // Panel pins
  output logic cmd_data_select_out,
  output logic chip_select_out,
  output logic serial_clock_out,
  output logic [17:0] panel_data_bus
);
  import spwi_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACT, S_RET, S_STROBE, S_END} spwi_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic pready_reg, pslverr_reg, dma_en_reg, busy_reg, dma_req_reg, drive_reg;
  logic [31:0] prdata_reg, cfg_reg, direct_reg, queued_reg;
  spwi_word_t mem [SPWI_FIFO_DEPTH];
  logic [SPWI_FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [4:0] cnt_reg, cnt_next, bit_reg, bit_next;
  spwi_state_t state_reg, state_next;
  spwi_word_t cur_reg;
  logic [1:0] idx_reg, idx_next;
  logic [2:0] tmr_reg;
  logic cs_reg, rs_reg, sck_reg;
  logic [17:0] dat_reg;
  spwi_beat_t beat;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire [1:0] thr_code = cfg_reg[SPWI_THR_LSB +: 2];
  wire [2:0] dfmt = cfg_reg[SPWI_DFMT_LSB +: 3];
  wire [1:0] cfmt = cfg_reg[SPWI_CFMT_LSB +: 2];
  wire cspol = cfg_reg[SPWI_CSPOL_BIT];
  wire rspol = cfg_reg[SPWI_RSPOL_BIT];
  wire ckpol = cfg_reg[SPWI_CKPOL_BIT];
  wire serial = cfg_reg[SPWI_KIND_BIT];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire done = access & pready_reg;
  wire hit_cfg = paddr == SPWI_CFG_ADDR;
  wire hit_ctrl = paddr == SPWI_CTRL_ADDR;
  wire hit_state = paddr == SPWI_STATE_ADDR;
  wire hit_dir = paddr == SPWI_DIRECT_ADDR;
  wire hit_que = paddr == SPWI_QUEUED_ADDR;
  wire mapped = hit_cfg | hit_ctrl | hit_state | hit_dir | hit_que;
  wire fifo_full = cnt_reg == SPWI_FIFO_FULL;
  wire can_go = ~(pwrite & (hit_dir | hit_que) & fifo_full);
  wire wr_done = done & pwrite & clk_en;
  wire push = wr_done & (hit_dir | hit_que);
  wire [31:0] word_in = pwdata & SPWI_WORD_WMASK;
  wire [31:0] rd_mux = hit_cfg ? cfg_reg :
                       hit_ctrl ? {31'h0, dma_en_reg} :
                       hit_state ? {31'h0, busy_reg} :
                       hit_dir ? direct_reg :
                       hit_que ? queued_reg : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready_reg <= access & ~pready_reg & can_go;
      pslverr_reg <= access & ~pready_reg & can_go & ~mapped;
      prdata_reg <= (access & ~pready_reg) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= SPWI_CFG_RST;
      dma_en_reg <= SPWI_CTRL_RST;
      direct_reg <= SPWI_WORD_RST;
      queued_reg <= SPWI_WORD_RST;
    end
    else if (wr_done)
    begin
      if (hit_cfg)
        cfg_reg <= pwdata & SPWI_CFG_WMASK; // RL13
      if (hit_ctrl)
        dma_en_reg <= pwdata[SPWI_DMA_EN_BIT]; // RL15
      if (hit_dir)
        direct_reg <= word_in;
      if (hit_que)
        queued_reg <= word_in;
    end
  end

  // ----------------------------------------------------------------
  // Word queue
  // ----------------------------------------------------------------
  wire start = (state_reg == S_IDLE) & (cnt_reg != 5'h00) & pin_share_select; // RL14
  wire pop = start & clk_en;
  wire [4:0] free = SPWI_FIFO_FULL - cnt_reg;
  wire [4:0] thr_words = (thr_code == SPWI_THR_8) ? SPWI_THR8_WORDS : SPWI_THR4_WORDS;

  assign cnt_next = cnt_reg + 5'(push) - 5'(pop);

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= '{is_cmd: pwdata[SPWI_CMD_BIT], body: pwdata[23:0]}; // RL17
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= 5'h00;
      dma_req_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_ptr_reg <= wr_ptr_reg + SPWI_FIFO_AW'(push);
      rd_ptr_reg <= rd_ptr_reg + SPWI_FIFO_AW'(pop);
      cnt_reg <= cnt_next;
      dma_req_reg <= dma_en_reg & (free >= thr_words); // RL1 RL15
    end
  end

  // ----------------------------------------------------------------
  // Beat sequencer
  // ----------------------------------------------------------------
  spwi_beat_sel u_beat (
    .word(cur_reg),
    .dfmt(dfmt),
    .cfmt(cfmt),
    .idx(idx_reg),
    .beat(beat)
  );

  wire half_done = tmr_reg == SPWI_HALF_LAST;
  wire last_beat = idx_reg == beat.last_idx;

  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    bit_next = bit_reg;
    unique case (state_reg)
      S_IDLE:
        if (start)
        begin
          state_next = S_SETUP;
          idx_next = 2'd0;
        end
      S_SETUP:
        if (half_done)
        begin
          state_next = serial ? S_ACT : S_STROBE; // RL8 RL9
          bit_next = beat.width - 5'd1;
        end
      S_ACT:
        if (half_done)
          state_next = S_RET;
      S_RET:
        if (half_done)
        begin
          state_next = (bit_reg == 5'd0) ? S_END : S_ACT;
          bit_next = bit_reg - 5'd1;
        end
      S_STROBE:
        if (half_done)
          state_next = S_END;
      S_END:
        if (half_done)
        begin
          state_next = last_beat ? S_IDLE : S_SETUP; // RL18
          idx_next = idx_reg + 2'd1;
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_IDLE;
      idx_reg <= 2'd0;
      bit_reg <= 5'd0;
      tmr_reg <= 3'd0;
      cur_reg <= '0;
      busy_reg <= SPWI_STATE_RST;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      bit_reg <= bit_next;
      tmr_reg <= (state_reg == S_IDLE || half_done) ? 3'd0 : tmr_reg + 3'd1;
      if (pop)
        cur_reg <= mem[rd_ptr_reg];
      busy_reg <= (state_next != S_IDLE) | (cnt_next != 5'h00); // RL16
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire frame = (state_reg == S_SETUP) | (state_reg == S_ACT) | (state_reg == S_RET);
  wire cs_act = (serial & frame) | (~serial & (state_reg == S_STROBE)); // RL9
  wire sck_idle = ~ckpol; // RL7
  wire [4:0] sel_bit = (state_reg == S_SETUP) ? beat.width - 5'd1 :
                       (state_reg == S_RET && bit_reg != 5'd0) ? bit_reg - 5'd1 : bit_reg;
  wire ser_bit = frame & beat.value[sel_bit];
  wire [17:0] ser_bus = {2'b00, ser_bit, 15'h0000};
  wire in_beat = state_reg != S_IDLE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_reg <= 1'b1;
      rs_reg <= 1'b1;
      sck_reg <= 1'b1;
      dat_reg <= 18'h0_0000;
      drive_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cs_reg <= cs_act ? cspol : ~cspol; // RL5
      if (in_beat)
        rs_reg <= ~cur_reg.is_cmd ^ rspol; // RL6 RL10
      sck_reg <= (serial & (state_reg == S_ACT)) ? ~sck_idle : sck_idle; // RL11
      dat_reg <= serial ? ser_bus : (in_beat ? beat.value : 18'h0_0000); // RL8 RL12
      drive_reg <= pin_share_select; // RL14
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign dma_req = dma_req_reg;
  assign panel_drive_en = drive_reg;
  assign cmd_data_select_out = rs_reg;
  assign chip_select_out = cs_reg;
  assign serial_clock_out = sck_reg;
  assign panel_data_bus = dat_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_par_setup_end;
    clk_en && state_reg == S_SETUP && half_done && !serial;
  endsequence

  sequence s_ser_bit_end;
    clk_en && state_reg == S_ACT && half_done;
  endsequence

  a_thr_request: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    clk_en && dma_en_reg && free >= thr_words |=> dma_req)
    else $error("refill request missing above threshold");
  a_dma_gate: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    clk_en && !dma_en_reg |=> !dma_req)
    else $error("refill request without dma enable");
  a_cs_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    clk_en && state_reg == S_IDLE |=> chip_select_out == !$past(cspol))
    else $error("chip select not inactive in idle");
  a_par_strobe: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    s_par_setup_end ##1 clk_en |=> chip_select_out == $past(cspol, 2))
    else $error("parallel strobe not active");
  a_rs_level: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    clk_en && in_beat |=> cmd_data_select_out == ($past(rspol) ^ !$past(cur_reg.is_cmd)))
    else $error("command/data select wrong level");
  a_sck_edge: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    s_ser_bit_end ##1 clk_en |=> serial_clock_out == !$past(ckpol, 2) && state_reg == S_RET)
    else $error("serial clock not back at idle level");
  a_sck_parallel: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    clk_en && !serial |=> serial_clock_out == !$past(ckpol))
    else $error("serial clock moved in parallel mode");
  a_ser_pin: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    clk_en && serial |=> panel_data_bus[14:0] == 15'h0000 && panel_data_bus[17:16] == 2'b00)
    else $error("serial data not on bit 15 alone");
  a_par_lines: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    clk_en && !serial && in_beat |=> (panel_data_bus >> $past(beat.width)) == 18'h0_0000)
    else $error("parallel beat uses lines above width");
  a_busy_push: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    push |=> busy_reg [*2])
    else $error("busy not raised for queued word");
  a_cfg_resv: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    (cfg_reg & ~SPWI_CFG_WMASK) == 32'h0000_0000)
    else $error("reserved configuration bits set");
  a_beat_next: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    clk_en && state_reg == S_END && half_done && !last_beat
    |=> state_reg == S_SETUP && idx_reg == $past(idx_reg) + 2'd1 && cur_reg == $past(cur_reg))
    else $error("beat order broken");

endmodule : spwi_top
`default_nettype wire

// [spwi_pkg.sv]
// Constants, codes and carrier types of the smart panel write interface.
// Assumes a 20 MHz pclk and an APB master with 32-bit data.
//
// Contract
// RL1: Threshold field picks four or eight word refill
// RL2: Data beat format selects width and beat count
// RL3: Command beat format selects one command beat width
// RL4: Software pairs command and data formats legally
// RL5: Chip select polarity programmable, idles at inactive
// RL6: Select line level follows command/data polarity
// RL7: Clock polarity bit picks active serial edge
// RL8: Serial mode shifts data out on bit 15
// RL9: Chip select frames serial, strobes parallel data
// RL10: Command/data select driven during every beat
// RL11: Serial clock toggles only in serial mode
// RL12: Parallel beats use low bus lines only
// RL13: Reserved configuration bits read zero, ignore writes
// RL14: Panel pins driven only when pins handed over
// RL15: DMA enable starts refill; clear after idle
// RL16: Busy set during transfer, cleared by hardware
// RL17: Word bit 31 marks low 24 bits command
// RL18: Most significant beat first, select held steady
package spwi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] SPWI_CFG_ADDR = 32'h1305_00a0;
  localparam logic [31:0] SPWI_CTRL_ADDR = 32'h1305_00a4;
  localparam logic [31:0] SPWI_STATE_ADDR = 32'h1305_00a8;
  localparam logic [31:0] SPWI_DIRECT_ADDR = 32'h1305_00ac;
  localparam logic [31:0] SPWI_QUEUED_ADDR = 32'h1305_00b0;
  localparam logic [31:0] SPWI_CFG_RST = 32'h0000_0000;
  localparam logic SPWI_CTRL_RST = 1'b0;
  localparam logic SPWI_STATE_RST = 1'b0;
  localparam logic [31:0] SPWI_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] SPWI_CFG_WMASK = 32'h0000_df1b;
  localparam logic [31:0] SPWI_WORD_WMASK = 32'h80ff_ffff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPWI_THR_LSB = 14;
  localparam int SPWI_DFMT_LSB = 10;
  localparam int SPWI_CFMT_LSB = 8;
  localparam int SPWI_CSPOL_BIT = 4;
  localparam int SPWI_RSPOL_BIT = 3;
  localparam int SPWI_CKPOL_BIT = 1;
  localparam int SPWI_KIND_BIT = 0;
  localparam int SPWI_DMA_EN_BIT = 0;
  localparam int SPWI_BUSY_BIT = 0;
  localparam int SPWI_CMD_BIT = 31;
  localparam int SPWI_SER_PIN = 15;

  // ----------------------------------------------------------------
  // Format and threshold codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SPWI_DF_18X1 = 3'h0;
  localparam logic [2:0] SPWI_DF_16X1 = 3'h1;
  localparam logic [2:0] SPWI_DF_8X3 = 3'h2;
  localparam logic [2:0] SPWI_DF_8X2 = 3'h3;
  localparam logic [2:0] SPWI_DF_8X1 = 3'h4;
  localparam logic [2:0] SPWI_DF_9X2 = 3'h7;
  localparam logic [1:0] SPWI_CF_16 = 2'h0;
  localparam logic [1:0] SPWI_CF_8 = 2'h1;
  localparam logic [1:0] SPWI_CF_18 = 2'h2;
  localparam logic [1:0] SPWI_THR_8 = 2'h1;
  localparam logic [4:0] SPWI_THR4_WORDS = 5'h04;
  localparam logic [4:0] SPWI_THR8_WORDS = 5'h08;
  localparam logic [4:0] SPWI_W18 = 5'h12;
  localparam logic [4:0] SPWI_W16 = 5'h10;
  localparam logic [4:0] SPWI_W9 = 5'h09;
  localparam logic [4:0] SPWI_W8 = 5'h08;

  // ----------------------------------------------------------------
  // Queue and timing
  // ----------------------------------------------------------------
  localparam int SPWI_FIFO_AW = 4;
  localparam int SPWI_FIFO_DEPTH = 16;
  localparam logic [4:0] SPWI_FIFO_FULL = 5'h10;
  localparam int SPWI_CLK_NS = 50;
  localparam int SPWI_HALF_NS = 100;
  localparam int SPWI_HALF_CYC = (SPWI_HALF_NS + SPWI_CLK_NS - 1) / SPWI_CLK_NS;
  localparam logic [2:0] SPWI_HALF_LAST = 3'(SPWI_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_cmd;
    logic [23:0] body;
  } spwi_word_t;

  typedef struct packed {
    logic [1:0] last_idx;
    logic [4:0] width;
    logic [17:0] value;
  } spwi_beat_t;

endpackage : spwi_pkg

// [spwi_beat_sel.sv]
// Beat selector: splits one queued word into panel beats.
// Assumes idx never exceeds the last_idx it reports.
`timescale 1ns/1ps
`default_nettype none
module spwi_beat_sel (
  // Word and formats
  input wire spwi_pkg::spwi_word_t word,
  input wire logic [2:0] dfmt,
  input wire logic [1:0] cfmt,
  input wire logic [1:0] idx,
  // Selected beat
  output spwi_pkg::spwi_beat_t beat
);
  import spwi_pkg::*;

  wire [23:0] b = word.body;
  wire [17:0] pix18 = {b[23:18], b[15:10], b[7:2]};
  wire [7:0] byte3 = (idx == 2'd0) ? b[23:16] : (idx == 2'd1) ? b[15:8] : b[7:0];
  wire [7:0] byte2 = (idx == 2'd0) ? b[15:8] : b[7:0];
  wire [8:0] nine2 = (idx == 2'd0) ? pix18[17:9] : pix18[8:0];

  always_comb
  begin
    beat = '0;
    if (word.is_cmd)
    begin
      unique case (cfmt) // RL3
        SPWI_CF_16:
        begin
          beat.width = SPWI_W16;
          beat.value = {2'b00, b[15:0]};
        end
        SPWI_CF_18:
        begin
          beat.width = SPWI_W18;
          beat.value = b[17:0];
        end
        default:
        begin
          beat.width = SPWI_W8;
          beat.value = {10'h000, b[7:0]};
        end
      endcase
    end
    else
    begin
      unique case (dfmt) // RL2 RL18
        SPWI_DF_18X1:
        begin
          beat.width = SPWI_W18;
          beat.value = pix18;
        end
        SPWI_DF_16X1:
        begin
          beat.width = SPWI_W16;
          beat.value = {2'b00, b[15:0]};
        end
        SPWI_DF_8X3:
        begin
          beat.last_idx = 2'd2;
          beat.width = SPWI_W8;
          beat.value = {10'h000, byte3};
        end
        SPWI_DF_8X2:
        begin
          beat.last_idx = 2'd1;
          beat.width = SPWI_W8;
          beat.value = {10'h000, byte2};
        end
        SPWI_DF_9X2:
        begin
          beat.last_idx = 2'd1;
          beat.width = SPWI_W9;
          beat.value = {9'h000, nine2};
        end
        default:
        begin
          beat.width = SPWI_W8;
          beat.value = {10'h000, b[7:0]};
        end
      endcase
    end
  end

endmodule : spwi_beat_sel
`default_nettype wire

// [spwi_panel_model.sv]
// Panel model: captures each beat that the interface writes.
// Assumes the bench hands in polarities and mode once the pins are idle.
`timescale 1ns/1ps
`default_nettype none
module spwi_panel_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Panel pins
  input wire logic cd_sel,
  input wire logic chip_sel,
  input wire logic ser_clk,
  input wire logic [17:0] dbus,
  // Setup
  input wire logic sel_pol,
  input wire logic ck_pol,
  input wire logic ser,
  // Captured beat
  output logic got,
  output logic [17:0] got_val,
  output logic got_cd
);
  logic sel_q;
  logic clk_q;
  logic [17:0] sh;
  wire logic act = (chip_sel == sel_pol);
  wire logic was = (sel_q == sel_pol);
  wire logic hit = ser && act && (clk_q != ser_clk) && (ser_clk == ck_pol);
  // ----------------------------------------------------------------
  // Sample on the select release edge
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sel_q <= 1'h1;
      clk_q <= 1'h1;
      got <= 1'h0;
    end
    else
    begin
      sel_q <= chip_sel;
      clk_q <= ser_clk;
      got <= was && !act;
      sh <= hit ? {sh[16:0], dbus[15]} : (act ? sh : 18'h0);
      if (was && !act)
      begin
        got_val <= ser ? sh : dbus;
        got_cd <= cd_sel;
      end
    end
endmodule : spwi_panel_model
`default_nettype wire

// [test_spwi_top.sv]
// Testbench of the smart panel write interface against a panel model.
// Assumes the design carries its own assertions; every beat is compared.
`timescale 1ns/1ps
`default_nettype none
module test_spwi_top;
  import spwi_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pin_share = 1'h0, sel_pol = 1'h0, ck_pol = 1'h0, ser = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, cfg;
  logic pready, pslverr, dma_req, drive_en, cd_sel, chip_sel, ser_clk, got, got_cd, err;
  logic sck_d = 1'h1;
  logic [17:0] dbus, got_val;
  logic [18:0] exp_q[$];
  logic [4:0] pairs [6] = '{{SPWI_DF_18X1, SPWI_CF_18}, {SPWI_DF_16X1, SPWI_CF_16},
    {SPWI_DF_9X2, SPWI_CF_16}, {SPWI_DF_8X3, SPWI_CF_8}, {SPWI_DF_8X2, SPWI_CF_8},
    {SPWI_DF_8X1, SPWI_CF_8}};
  logic [31:0] regs [5] = '{SPWI_CFG_ADDR, SPWI_CTRL_ADDR, SPWI_STATE_ADDR,
    SPWI_DIRECT_ADDR, SPWI_QUEUED_ADDR};
  int fails = 0, checked = 0, cycles = 0, toggles = 0, t0;
  integer seed = 32'hc2ee_aa3c;

  always #25 pclk = ~pclk;

  spwi_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .dma_req(dma_req), .pin_share_select(pin_share),
    .panel_drive_en(drive_en), .cmd_data_select_out(cd_sel), .chip_select_out(chip_sel),
    .serial_clock_out(ser_clk), .panel_data_bus(dbus));
  spwi_panel_model panel_u (.pclk(pclk), .presetn(presetn), .cd_sel(cd_sel),
    .chip_sel(chip_sel), .ser_clk(ser_clk), .dbus(dbus), .sel_pol(sel_pol),
    .ck_pol(ck_pol), .ser(ser), .got(got), .got_val(got_val), .got_cd(got_cd));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_idle();
    settle(2);
    do
      apb(1'h0, SPWI_STATE_ADDR, 32'h0);
    while (rd[0] !== 1'h0);
  endtask : wait_idle

  // Writes the configuration, then tells the panel model once the pins rest
  task automatic set_cfg(input logic [31:0] c);
    cfg = c;
    apb(1'h1, SPWI_CFG_ADDR, c);
    settle(4);
    sel_pol <= c[4];
    ck_pol <= c[1];
    ser <= c[0];
    settle(2);
  endtask : set_cfg

  // Expected beats of one word, most significant portion first
  task automatic push(input logic [31:0] addr, input logic [31:0] w);
    logic [23:0] src;
    logic cd_lvl;
    int n;
    int wd;
    cd_lvl = w[31] ~^ cfg[3];
    src = w[23:0];
    n = 1;
    wd = 8;
    if (w[31])
      wd = (cfg[9:8] == SPWI_CF_16) ? 16 : (cfg[9:8] == SPWI_CF_18) ? 18 : 8;
    else
      case (cfg[12:10])
        SPWI_DF_18X1: wd = 18;
        SPWI_DF_16X1: wd = 16;
        SPWI_DF_8X3: n = 3;
        SPWI_DF_8X2: n = 2;
        SPWI_DF_9X2: wd = 9;
        default: n = 1;
      endcase
    if (!w[31] && (wd == 18 || wd == 9))
      src = {6'h0, w[23:18], w[15:10], w[7:2]};
    if (wd == 9)
      n = 2;
    for (int i = n - 1; i >= 0; i--)
      exp_q.push_back({cd_lvl, 18'((src >> (wd * i)) & ((24'h1 << wd) - 24'h1))});
    apb(1'h1, addr, w);
  endtask : push

  always @(posedge pclk)
    if (got === 1'h1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0, "unexpected beat");
      else
        check({got_cd, got_val}, exp_q.pop_front(), "beat");
    end

  always @(posedge pclk)
  begin
    sck_d <= ser_clk;
    if (presetn && !ser && sck_d !== ser_clk)
      toggles <= toggles + 1;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      check(32'h1, 32'h0, "timeout");
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (regs[i])
    begin
      apb(1'h0, regs[i], 32'h0);
      check(rd, 32'h0, "reset value");
    end
    apb(1'h0, SPWI_QUEUED_ADDR + 32'h4, 32'h0);
    check(32'(err), 32'h1, "unmapped error");
    set_cfg(32'hffff_ffff);
    apb(1'h0, SPWI_CFG_ADDR, 32'h0);
    check(rd, 32'h0000_df1b, "config reserved bits");
    apb(1'h1, SPWI_STATE_ADDR, 32'h1);
    apb(1'h0, SPWI_STATE_ADDR, 32'h0);
    check(rd, 32'h0, "busy written by software");
    check(32'(drive_en), 32'h0, "pins kept");
    set_cfg({19'h0, SPWI_DF_8X1, SPWI_CF_8, 8'h00});
    apb(1'h1, SPWI_CTRL_ADDR, 32'hff);
    apb(1'h0, SPWI_CTRL_ADDR, 32'h0);
    check(rd, 32'h1, "control bits");
    push(SPWI_DIRECT_ADDR, 32'hffff_ffff);
    apb(1'h0, SPWI_DIRECT_ADDR, 32'h0);
    check(rd, 32'h80ff_ffff, "word reserved bits");
    for (int k = 2; k <= 16; k++)
    begin
      push(SPWI_QUEUED_ADDR, $random(seed));
      if (k == 10)
      begin
        cfg[15:14] = SPWI_THR_8;
        apb(1'h1, SPWI_CFG_ADDR, cfg);
      end
      settle(3);
      check(32'(dma_req), 32'((16 - k) >= (k >= 10 ? 8 : 4)), "refill request");
    end
    apb(1'h0, SPWI_STATE_ADDR, 32'h0);
    check(rd, 32'h1, "busy while pins held");
    check(32'(chip_sel), 32'h1, "select idle while held");
    pin_share <= 1'h1;
    wait_idle();
    check(32'(drive_en), 32'h1, "pins handed over");
    apb(1'h1, SPWI_CTRL_ADDR, 32'h0);
    settle(3);
    check(32'(dma_req), 32'h0, "refill stopped");
    for (int s = 0; s < 2; s++)
      foreach (pairs[p])
      begin
        if (s == 1 && p == 2)
          continue;
        t0 = $random(seed);
        set_cfg({19'h0, pairs[p], 3'h0, t0[2:1], 1'h0, t0[0], 1'(s)});
        check(32'(chip_sel), 32'(!cfg[4]), "select idle level");
        check(32'(ser_clk), 32'(!cfg[1]), "clock idle level");
        t0 = toggles;
        repeat (3)
          push(t0[0] ? SPWI_QUEUED_ADDR : SPWI_DIRECT_ADDR, $random(seed));
        wait_idle();
        settle(4);
        check(32'(toggles - t0), 32'h0, "clock in parallel");
        check(32'(exp_q.size()), 32'h0, "beats lost");
      end
    test_done();
  end
endmodule : test_spwi_top
`default_nettype wire
